// *** design/adc_seq_pkg.sv ***
package adc_seq_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CHAN = 4'h1;
  localparam logic [3:0] OFS_CLKDIV = 4'h2;
  localparam logic [3:0] OFS_LIM_HI = 4'h3;
  localparam logic [3:0] OFS_LIM_LO = 4'h4;
  localparam logic [3:0] OFS_IE = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;
  localparam logic [3:0] OFS_CMD = 4'h7;
  localparam logic [3:0] OFS_RES0 = 4'h8;
  localparam logic [3:0] OFS_RES3 = 4'hb;

  // Field positions in the flag registers
  localparam int IE_CONV = 0;
  localparam int IE_BND = 1;
  localparam int STAT_DONE = 0;
  localparam int STAT_BND = 1;
  localparam int STAT_BUSY = 2;
  localparam int CMD_STOP = 0;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [2:0] CLKDIV_RST = 3'h0;
  localparam logic [7:0] LIM_HI_RST = 8'hff;
  localparam logic [7:0] LIM_LO_RST = 8'h00;
  localparam logic [7:0] RES_RST = 8'h00;

  // Converter shape and timing, counted in converter clock ticks
  localparam int NCH = 4;
  localparam int SAMPLE_TICKS = 2;
  localparam logic [1:0] SAMPLE_LAST = 2'(SAMPLE_TICKS - 1);
  localparam logic [7:0] SAR_FIRST = 8'h80;
  localparam logic [7:0] SAR_NIBBLE = 8'h10;
  localparam logic [7:0] SAR_LAST = 8'h01;
  localparam logic [1:0] SLOT_LAST = 2'h3;

  // Operating modes and start sources
  typedef enum logic [2:0] {
    MODE_FIX_SINGLE, MODE_FIX_CONT, MODE_SCAN_SINGLE,
    MODE_SCAN_CONT, MODE_DUAL_CONT, MODE_STEP
  } mode_t;
  typedef enum logic [1:0] {
    SRC_TIMER, SRC_IMMED, SRC_EDGE, SRC_OFF
  } src_t;
  typedef enum logic [1:0] {C_IDLE, C_SAMPLE, C_BITS} conv_state_t;

  // Control register layout
  typedef struct packed {
    logic spare;
    logic dac_mode;
    logic [1:0] src;
    logic [2:0] mode;
    logic enable;
  } ctrl_t;

  // Channel selection register layout
  typedef struct packed {
    logic [1:0] ch_b;
    logic [1:0] ch_a;
    logic [3:0] scan_mask;
  } chan_t;

endpackage

// *** design/adc_sequencer_control.sv ***
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 8-bit SAR over four muxed sampled channels
// - Fixed single: one result into channel register
// - Fixed continuous: results rotate through four registers
// - Fixed continuous: interrupt every four conversions
// - Continuous modes run until software stop
// - Scan single: each selected channel once, one interrupt
// - Scan continuous: restart at lowest selected channel
// - Dual: alternate channels into registers zero-three
// - Dual: interrupt after every four conversions
// - Single step: pause per channel, await start
// - Timer overflow starts; ignored while converting
// - Immediate source starts a conversion at once
// - Pin edge starts; ignored while converting
// - Early nibble checked against limit nibbles
// - In-range nibble: full result checked again
// - Boundary enable off disables limit checking
// - DAC mode: fourth result drives channel-3 pin
// - Prescaler divides converter clock by 1..8
// - Runs in idle; completion wakes device
// - Power-down stops converter; disable saves power
module adc_sequencer_control
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // Register port
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Start sources
  input wire logic I_TIMER0_OVF,
  input wire logic I_START_EDGE_PIN,
  // Power management
  input wire logic I_IDLE,
  input wire logic I_POWER_DOWN,
  output logic O_WAKE,
  output logic O_ANALOG_EN,
  // Analog front end
  input wire logic I_CMP_ABOVE,
  output logic [1:0] O_MUX_SEL,
  output logic O_SAMPLE,
  output logic [7:0] O_DAC_CODE,
  output logic O_DAC_PIN_EN,
  // Interrupt request
  output logic O_IRQ
);

  ctrl_t ctrl;
  chan_t chan;
  mode_t mode;
  conv_state_t state;
  logic [2:0] clkdiv, pre_cnt, above, lowest;
  logic [7:0] lim_hi, lim_lo, sar, mask, next_sar, dac_code;
  logic [1:0] ie, smp_cnt, cur_ch, slot, dest;
  logic [7:0] res [NCH];
  logic done_flag, bnd_flag, tick, active, conv_done, nib_done;
  logic run, auto_go, immed_req, pin_prev, evt, launch;
  logic stop, scan_mode, seq_irq, early_out, wr_ctrl, wr_status;

  assign mode = mode_t'(ctrl.mode);
  assign wr_ctrl = I_WR && I_ADDR == OFS_CTRL;
  assign wr_status = I_WR && I_ADDR == OFS_STATUS;
  assign scan_mode = mode == MODE_SCAN_SINGLE || mode == MODE_SCAN_CONT ||
                     mode == MODE_STEP;

  // Converter runs only when enabled and not powered down
  assign active = ctrl.enable && !I_POWER_DOWN;
  assign stop = I_WR && I_ADDR == OFS_CMD && I_WDATA[CMD_STOP];

  // Finds the next selected channel above a given one
  function automatic logic [2:0] next_above(input logic [3:0] m,
                                            input logic [1:0] ch);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i] && i > int'(ch)) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // Finds the lowest selected channel
  function automatic logic [2:0] lowest_sel(input logic [3:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  assign above = next_above(chan.scan_mask, cur_ch);
  assign lowest = lowest_sel(chan.scan_mask);

  // Configuration registers written by software
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl <= CTRL_RST;
      chan <= CHAN_RST;
      clkdiv <= CLKDIV_RST;
      lim_hi <= LIM_HI_RST;
      lim_lo <= LIM_LO_RST;
      ie <= 2'h0;
    end else if (I_WR) begin
      unique case (I_ADDR)
        OFS_CTRL: ctrl <= I_WDATA;
        OFS_CHAN: chan <= I_WDATA;
        OFS_CLKDIV: clkdiv <= I_WDATA[2:0];
        OFS_LIM_HI: lim_hi <= I_WDATA;
        OFS_LIM_LO: lim_lo <= I_WDATA;
        OFS_IE: ie <= I_WDATA[1:0];
        default: ;
      endcase
    end
  end

  // Prescaler: one converter tick every clkdiv+1 system clocks
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pre_cnt <= 3'h0;
    end else if (!active || pre_cnt == clkdiv) begin
      pre_cnt <= 3'h0;
    end else begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end
  assign tick = active && pre_cnt == clkdiv;

  // Successive approximation step and event strobes
  assign next_sar = I_CMP_ABOVE ? (sar | mask) : sar;
  assign conv_done = state == C_BITS && tick && mask == SAR_LAST;
  assign nib_done = state == C_BITS && tick && mask == SAR_NIBBLE;

  // Conversion engine: sample, then resolve eight bits MSB first
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= C_IDLE;
      smp_cnt <= 2'h0;
      sar <= 8'h00;
      mask <= 8'h00;
    end else if (stop || !ctrl.enable) begin
      state <= C_IDLE;
      mask <= 8'h00;
    end else begin
      unique case (state)
        C_IDLE: begin
          if (launch) begin
            state <= C_SAMPLE;
            smp_cnt <= 2'h0;
            sar <= 8'h00;
            mask <= SAR_FIRST;
          end
        end
        C_SAMPLE: begin
          if (tick) begin
            smp_cnt <= smp_cnt + 2'h1;
            if (smp_cnt == SAMPLE_LAST) begin
              state <= C_BITS;
            end
          end
        end
        C_BITS: begin
          if (tick) begin
            sar <= next_sar;
            mask <= mask >> 1;
            if (mask == SAR_LAST) begin
              state <= C_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Code fed to the internal DAC: trial code or the held DAC value
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      dac_code <= 8'h00;
    end else if (ctrl.dac_mode) begin
      dac_code <= res[3];
    end else if (state == C_IDLE && launch) begin
      dac_code <= SAR_FIRST;
    end else if (state == C_BITS && tick) begin
      dac_code <= next_sar | (mask >> 1);
    end
  end

  // Start events from timer, pin edge or immediate request
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pin_prev <= 1'b0;
      immed_req <= 1'b0;
    end else begin
      pin_prev <= I_START_EDGE_PIN;
      if (wr_ctrl && I_WDATA[5:4] == SRC_IMMED && I_WDATA[0]) begin
        immed_req <= 1'b1;
      end else if (stop || state == C_IDLE) begin
        immed_req <= 1'b0; // Taken or refused once idle; held while a conversion runs
      end
    end
  end

  always_comb begin
    evt = 1'b0;
    unique case (src_t'(ctrl.src))
      SRC_TIMER: evt = I_TIMER0_OVF;
      SRC_IMMED: evt = immed_req;
      SRC_EDGE: evt = I_START_EDGE_PIN != pin_prev;
      SRC_OFF: evt = 1'b0;
    endcase
  end

  // Timer and pin events arriving while a conversion runs are dropped
  assign launch = active && !ctrl.dac_mode && !stop && state == C_IDLE &&
                  (auto_go || (evt && !auto_go &&
                  !(scan_mode && chan.scan_mask == 4'h0)));

  // Result slot for the finishing conversion
  assign dest = (mode == MODE_FIX_CONT || mode == MODE_DUAL_CONT) ?
                slot : cur_ch;

  // Sequencer: channel order, slot rotation and completion events
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      run <= 1'b0;
      auto_go <= 1'b0;
      cur_ch <= 2'h0;
      slot <= 2'h0;
    end else if (stop || !ctrl.enable) begin
      run <= 1'b0;
      auto_go <= 1'b0;
    end else if (launch) begin
      auto_go <= 1'b0;
      if (!run) begin
        run <= 1'b1;
        slot <= 2'h0;
        cur_ch <= scan_mode ? lowest[1:0] : chan.ch_a;
      end
    end else if (conv_done) begin
      slot <= slot + 2'h1;
      unique case (mode)
        MODE_FIX_CONT: auto_go <= 1'b1;
        MODE_DUAL_CONT: begin
          cur_ch <= slot[0] ? chan.ch_a : chan.ch_b;
          auto_go <= 1'b1;
        end
        MODE_SCAN_SINGLE, MODE_SCAN_CONT, MODE_STEP: begin
          if (above[2]) begin
            cur_ch <= above[1:0];
            auto_go <= mode != MODE_STEP;
          end else begin
            cur_ch <= lowest[1:0];
            auto_go <= mode == MODE_SCAN_CONT;
            run <= mode == MODE_SCAN_CONT;
          end
        end
        default: run <= 1'b0;
      endcase
    end
  end

  // Completion event per mode
  always_comb begin
    seq_irq = 1'b0;
    if (conv_done) begin
      unique case (mode)
        MODE_FIX_CONT: seq_irq = slot == SLOT_LAST;
        MODE_DUAL_CONT: seq_irq = slot == SLOT_LAST;
        MODE_SCAN_SINGLE, MODE_SCAN_CONT: seq_irq = !above[2];
        MODE_STEP: seq_irq = 1'b1;
        default: seq_irq = 1'b1;
      endcase
    end
  end

  // Result registers; the fourth doubles as the DAC value
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      for (int i = 0; i < NCH; i++) begin
        res[i] <= RES_RST;
      end
    end else if (conv_done) begin
      res[dest] <= next_sar;
    end else if (I_WR && I_ADDR == OFS_RES3) begin
      res[3] <= I_WDATA;
    end
  end

  // Boundary check: early nibble, then full result if nibble in range
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      early_out <= 1'b0;
    end else if (launch) begin
      early_out <= 1'b0;
    end else if (nib_done) begin
      early_out <= next_sar[7:4] > lim_hi[7:4] ||
                   next_sar[7:4] < lim_lo[7:4];
    end
  end

  // Sticky status flags; a new event beats a clear in the same cycle
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      done_flag <= 1'b0;
      bnd_flag <= 1'b0;
    end else begin
      done_flag <= (done_flag && !(wr_status && I_WDATA[STAT_DONE])) ||
                   seq_irq;
      bnd_flag <= (bnd_flag && !(wr_status && I_WDATA[STAT_BND])) ||
                  (ie[IE_BND] && nib_done &&
                   (next_sar[7:4] > lim_hi[7:4] ||
                    next_sar[7:4] < lim_lo[7:4])) ||
                  (ie[IE_BND] && conv_done && !early_out &&
                   (next_sar > lim_hi ||
                    next_sar < lim_lo));
    end
  end

  // Read data stand for the one cycle after the read strobe
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
    end else if (!I_RD) begin
      O_RDATA <= 8'h00;
    end else begin
      unique case (I_ADDR)
        OFS_CTRL: O_RDATA <= ctrl;
        OFS_CHAN: O_RDATA <= chan;
        OFS_CLKDIV: O_RDATA <= {5'h00, clkdiv};
        OFS_LIM_HI: O_RDATA <= lim_hi;
        OFS_LIM_LO: O_RDATA <= lim_lo;
        OFS_IE: O_RDATA <= {6'h00, ie};
        OFS_STATUS: O_RDATA <= {5'h00, state != C_IDLE, bnd_flag,
                                done_flag};
        4'h8, 4'h9, 4'ha, 4'hb: O_RDATA <= res[I_ADDR[1:0]];
        default: O_RDATA <= 8'h00;
      endcase
    end
  end

  // Outputs toward the analog block; mux select may change as sampling starts, then holds
  assign O_MUX_SEL = cur_ch;
  assign O_SAMPLE = state == C_SAMPLE;
  assign O_DAC_CODE = dac_code;
  assign O_DAC_PIN_EN = ctrl.dac_mode && ctrl.enable;
  assign O_ANALOG_EN = active;
  assign O_IRQ = (done_flag && ie[IE_CONV]) || (bnd_flag && ie[IE_BND]);
  assign O_WAKE = I_IDLE && done_flag && ie[IE_CONV];

endmodule
`default_nettype wire

// *** tb/adc_inputs_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_inputs_model
(
  // Clock
  input wire logic i_clk,
  // Channel levels and converter drive
  input wire logic [31:0] i_level,
  input wire logic [1:0] i_sel,
  input wire logic i_sample,
  input wire logic [7:0] i_trial,
  // Comparator result
  output logic o_above
);
  logic [7:0] held = 8'h00;
  // Track the selected channel while sampling, hold it afterwards
  always_ff @(posedge i_clk) begin
    if (i_sample) begin
      held <= i_level[8 * i_sel +: 8];
    end
  end
  // Held level against the DAC trial
  assign o_above = held >= i_trial;
endmodule
`default_nettype wire

// *** tb/adc_seq_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // Watched ports
  input wire logic I_POWER_DOWN,
  input wire logic I_IDLE,
  input wire logic O_WAKE,
  input wire logic O_ANALOG_EN,
  input wire logic [1:0] O_MUX_SEL,
  input wire logic O_SAMPLE,
  input wire logic [7:0] O_DAC_CODE,
  input wire logic O_DAC_PIN_EN,
  input wire logic O_IRQ
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  // Power and DAC pin
  pd_off_a:
    assert property (I_POWER_DOWN |-> !O_ANALOG_EN)
    else $error("converter on in power down");
  dac_on_a:
    assert property (O_DAC_PIN_EN && !I_POWER_DOWN |-> O_ANALOG_EN)
    else $error("DAC pin on with converter off");
  wake_src_a:
    assert property (O_WAKE |-> I_IDLE && O_IRQ)
    else $error("wake without idle and request");
  // Sample phase shape
  sample_len_a:
    assert property ($fell(O_SAMPLE) |-> $past(O_SAMPLE, 2))
    else $error("sample phase under two cycles");
  mux_hold_a:
    assert property (O_SAMPLE && $past(O_SAMPLE) |-> $stable(O_MUX_SEL))
    else $error("channel changed while sampling");
  first_trial_a:
    assert property ($rose(O_SAMPLE) |-> O_DAC_CODE == SAR_FIRST)
    else $error("first trial code wrong");
  // No launch while powered down or in DAC mode
  pd_launch_a:
    assert property ($rose(O_SAMPLE) |-> !$past(I_POWER_DOWN))
    else $error("launch in power down");
  dac_launch_a:
    assert property ($rose(O_SAMPLE) |-> !$past(O_DAC_PIN_EN))
    else $error("launch in DAC mode");
endmodule
bind adc_sequencer_control adc_seq_chk chk (
  .I_CLK_SYS(I_CLK_SYS),
  .I_RESET_N(I_RESET_N),
  .I_POWER_DOWN(I_POWER_DOWN),
  .I_IDLE(I_IDLE),
  .O_WAKE(O_WAKE),
  .O_ANALOG_EN(O_ANALOG_EN),
  .O_MUX_SEL(O_MUX_SEL),
  .O_SAMPLE(O_SAMPLE),
  .O_DAC_CODE(O_DAC_CODE),
  .O_DAC_PIN_EN(O_DAC_PIN_EN),
  .O_IRQ(O_IRQ)
);
`default_nettype wire

// *** tb/adc_sequencer_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_tb
  import adc_seq_pkg::*;
;
  logic clk, rst_n, wr, rd, tmr, pin, idle, pd, above;
  logic sample, wake, aen, dpen, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, dac;
  logic [1:0] sel;
  logic [31:0] level;
  logic [7:0] res [4];
  int miscompares, tests_run, n, i;

  adc_sequencer_control dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_TIMER0_OVF(tmr), .I_START_EDGE_PIN(pin),
    .I_IDLE(idle), .I_POWER_DOWN(pd), .O_WAKE(wake),
    .O_ANALOG_EN(aen), .I_CMP_ABOVE(above), .O_MUX_SEL(sel),
    .O_SAMPLE(sample), .O_DAC_CODE(dac), .O_DAC_PIN_EN(dpen),
    .O_IRQ(irq));
  adc_inputs_model inputs (.i_clk(clk), .i_level(level), .i_sel(sel),
    .i_sample(sample), .i_trial(dac), .o_above(above));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Bus tasks and comparison
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Clear flags, pick channels, start a mode
  task go(input logic [7:0] chan, input logic [2:0] m, input src_t s);
    wreg(OFS_STATUS, 8'h03);
    wreg(OFS_CHAN, chan);
    wreg(OFS_CTRL, {2'b00, s, m, 1'b1});
  endtask
  // Wait for the request under a bound, counting cycles
  task wirq;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, irq}, 8'h01);
  endtask
  // Clear flags and expect no further request
  task quiet;
    wreg(OFS_STATUS, 8'h03);
    repeat (60) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
  endtask
  // Stop clear of the sample phase of a follow-on launch
  task stop;
    repeat (4) @(posedge clk);
    wreg(OFS_CMD, 8'h01);
  endtask
  task pulse;
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
  endtask
  task lim(input logic [7:0] v, input logic [7:0] ie, input logic [7:0] st);
    level[7:0] = v;
    wreg(OFS_IE, ie);
    go(8'h00, 3'd0, SRC_IMMED);
    wirq();
    // An early limit hit raises the request before the result is in
    repeat (8) @(posedge clk);
    rchk(OFS_STATUS, st);
  endtask
  task complete_run;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // Test sequence
  initial begin
    {wr, rd, tmr, pin, idle, pd} = 6'h00;
    addr = 4'h0;
    wdata = 8'h00;
    rst_n = 1'b0;
    level = 32'he547_9c21;
    miscompares = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFS_LIM_HI, LIM_HI_RST);
    rchk(OFS_CLKDIV, 8'h00);
    rchk(4'hc, 8'h00);
    // Fixed single, channel 2
    wreg(OFS_IE, 8'h01);
    go(8'h20, 3'd0, SRC_IMMED);
    wirq();
    chk({7'h00, n < 20}, 8'h01);
    rchk(OFS_RES0 + 4'h2, 8'h47);
    rchk(OFS_RES0, 8'h00);
    rchk(OFS_STATUS, 8'h01);
    // Scan single over channels 1 and 3, then an empty scan
    go(8'h0a, 3'd2, SRC_IMMED);
    wirq();
    quiet();
    rchk(OFS_RES0 + 4'h1, 8'h9c);
    rchk(OFS_RES3, 8'he5);
    go(8'h00, 3'd3, SRC_IMMED);
    repeat (40) @(posedge clk);
    rchk(OFS_STATUS, 8'h00);
    // Scan continuous passes until stopped
    go(8'h05, 3'd3, SRC_IMMED);
    wirq();
    wreg(OFS_STATUS, 8'h03);
    wirq();
    stop();
    quiet();
    // Dual continuous, channel 1 then 0
    go(8'h10, 3'd4, SRC_IMMED);
    wirq();
    chk({7'h00, n >= 40}, 8'h01);
    stop();
    quiet();
    res = '{8'h9c, 8'h21, 8'h9c, 8'h21};
    for (i = 0; i < 4; i++) rchk(OFS_RES0 + 4'(i), res[i]);
    // Fixed continuous on channel 3 by timer, extra pulse ignored
    go(8'h30, 3'd1, SRC_TIMER);
    pulse();
    pulse();
    wirq();
    chk({7'h00, n >= 40}, 8'h01);
    stop();
    quiet();
    for (i = 0; i < 4; i++) rchk(OFS_RES0 + 4'(i), 8'he5);
    // Single step over channels 0 and 1
    go(8'h03, 3'd5, SRC_TIMER);
    pulse();
    wirq();
    quiet();
    rchk(OFS_RES0, 8'h21);
    pulse();
    wirq();
    rchk(OFS_RES0 + 4'h1, 8'h9c);
    // Limits 10..35
    wreg(OFS_LIM_HI, 8'h35);
    wreg(OFS_LIM_LO, 8'h10);
    lim(8'h05, 8'h03, 8'h03);
    lim(8'h20, 8'h03, 8'h01);
    lim(8'h80, 8'h01, 8'h01);
    // Pin edge start while idle, late limit hit
    level[7:0] = 8'h38;
    wreg(OFS_IE, 8'h03);
    idle <= 1'b1;
    go(8'h00, 3'd0, SRC_EDGE);
    pin <= ~pin;
    wirq();
    chk({7'h00, wake}, 8'h01);
    rchk(OFS_STATUS, 8'h03);
    // Divide by 8
    wreg(OFS_CLKDIV, 8'h07);
    go(8'h00, 3'd0, SRC_IMMED);
    wirq();
    chk({7'h00, n >= 70}, 8'h01);
    rchk(OFS_RES0, 8'h38);
    // DAC output mode
    wreg(OFS_RES3, 8'h5a);
    wreg(OFS_CTRL, {2'b01, SRC_OFF, 3'd0, 1'b1});
    repeat (2) @(posedge clk);
    #1 chk(dac, 8'h5a);
    chk({7'h00, dpen}, 8'h01);
    // Power down
    pd <= 1'b1;
    @(posedge clk);
    #1 chk({7'h00, aen}, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
